//--- common/wdp_pkg.sv
// Package with register map, field layout and timing constants of the watchdog block.
package wdp_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [3:0] WDP_ADDR_WDCTL  = 4'h0;
  localparam logic [3:0] WDP_ADDR_OPTION = 4'h4;
  localparam logic [3:0] WDP_ADDR_STATUS = 4'h8;

  // ----------------------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------------------
  localparam logic [7:0] WDP_WDCTL_RST   = 8'h08;
  localparam logic [7:0] WDP_OPTION_RST  = 8'hff;
  localparam logic [7:0] WDP_WDCTL_MASK  = 8'h1f;
  localparam int         WDP_PSA_BIT     = 3;
  localparam logic [3:0] WDP_PS_MAXCODE  = 4'hb;
  localparam int         WDP_PS_BASE_LOG = 5;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int WDP_LFOSC_HZ    = 31000;
  localparam int WDP_SYS_HZ      = 100000000;
  localparam int WDP_LF_DIV      = WDP_SYS_HZ / WDP_LFOSC_HZ;
  localparam int WDP_OST_PERIODS = 1024;

endpackage

//--- hw/wdp_top.sv
// Watchdog timer with programmable and shared prescalers behind a Wishbone slave.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
// Operation
// - Watchdog counts only ticks of the 31 kHz low frequency oscillator.
// - Sixteen bit prescaler divides oscillator ticks by 32 up to 65536.
// - Eight bit prescaler serves either the watchdog or the general timer.
// - Period choices span roughly 1 ms to 268 seconds; the code reaches about 541 seconds with the shared prescaler at 1:256.
// - Every reset loads control value 0x08, 16 ms base, soft enable clear.
// - Oscillator status output ignores watchdog use of the oscillator.
// - Watchdog is held cleared while the start-up counter runs.
// - After start-up count ends, enabled watchdog counts from zero.
// - Configuration enable set forces watchdog on, soft enable ignored.
// - With configuration enable clear, bit 0 turns watchdog on or off.
// - Bits 4 to 1 select ratio 1:32 doubling to 1:65536; codes above reserved.
// - Disable, clear instruction, oscillator fail and fast wake clear the count.
// - Wake with crystal clock holds watchdog cleared until start-up ends.
// - Start-up counter counts 1024 slow clock periods.
// - Prescaler assign bit and rate field steer the shared prescaler.
module wdp_top #(
  parameter int LF_DIV   = wdp_pkg::WDP_LF_DIV,
  parameter int OST_LEN  = wdp_pkg::WDP_OST_PERIODS
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        watchdog_config_enable,
  input  wire logic        clear_watchdog_instr,
  input  wire logic        osc_fail,
  input  wire logic        wake_event,
  input  wire logic        wake_crystal,
  input  wire logic        core_sleeping,
  input  wire logic        low_freq_osc_on,
  output logic             low_freq_osc_status,
  output logic             watchdog_reset,
  output logic             watchdog_wake,
  output logic             timer_prescaler_free
);
  import wdp_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  // Run normally, or hold the count while the start-up counter borrows the chain.
  typedef enum logic [0:0] {WDP_RUN, WDP_OST} wdp_mode_t;

  // All registered state of the block.
  typedef struct packed {
    logic [7:0]  wdctl;
    logic [7:0]  option;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  cfg_sync;
    logic [15:0] lf_cnt;
    logic        lf_tick;
    logic [15:0] pre16;
    logic [7:0]  pre8;
    logic [10:0] ost_cnt;
    wdp_mode_t   mode;
    logic        rst_pulse;
    logic        wake_pulse;
  } wdp_state_t;

  // Current state and the value it takes at the next edge.
  wdp_state_t st_r;
  wdp_state_t st_nxt;

  // Decoded controls and prescaler terminal counts.
  logic        enabled;
  logic        wr_en;
  logic        rd_en;
  logic        clr_cnt;
  logic        pre16_hit;
  logic        pre8_hit;
  logic        wdt_ovf;
  logic [3:0]  ps_code;
  logic [15:0] ratio_mask;
  logic [7:0]  ps8_mask;

  // Effective enable and decoded period masks.
  assign enabled  = st_r.cfg_sync[1] | st_r.wdctl[0];
  assign ps_code  = (st_r.wdctl[4:1] > WDP_PS_MAXCODE) ? WDP_PS_MAXCODE : st_r.wdctl[4:1];
  assign ratio_mask = 16'((32'h1 << (32'(ps_code) + WDP_PS_BASE_LOG)) - 32'h1);
  assign ps8_mask = 8'((32'h1 << (32'(st_r.option[2:0]) + 1)) - 32'h1);
  // Bus strobes; a request is taken only while ack is low, so it acts once.
  assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack;
  assign rd_en    = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;
  // Clear sources of the watchdog count; any of them wins over a tick.
  assign clr_cnt  = ~enabled | clear_watchdog_instr | osc_fail
                  | (wake_event & ~wake_crystal) | (st_r.mode == WDP_OST);
  // Prescaler terminal counts, only meaningful on an oscillator tick.
  assign pre16_hit = st_r.lf_tick & ((st_r.pre16 & ratio_mask) == ratio_mask);
  assign pre8_hit  = pre16_hit & ((st_r.pre8 & ps8_mask) == ps8_mask);
  // Shared prescaler only counts for the watchdog when assigned to it.
  assign wdt_ovf  = ~clr_cnt & (st_r.option[WDP_PSA_BIT] ? pre8_hit : pre16_hit);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Bus slave, oscillator tick, prescalers, start-up counter and overflow.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.cfg_sync = {st_r.cfg_sync[0], watchdog_config_enable};
    // Register writes; a cleared low byte lane or an unmapped offset is ignored.
    if (wr_en && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        WDP_ADDR_WDCTL:  st_nxt.wdctl = wb_dat_i[7:0] & WDP_WDCTL_MASK;
        WDP_ADDR_OPTION: st_nxt.option = wb_dat_i[7:0];
        default: ;
      endcase
    end
    // Read data is captured with the request and held until the next read.
    if (rd_en) begin
      unique case (wb_adr_i)
        WDP_ADDR_WDCTL:  st_nxt.rdata = {24'h0, st_r.wdctl};
        WDP_ADDR_OPTION: st_nxt.rdata = {24'h0, st_r.option};
        WDP_ADDR_STATUS: st_nxt.rdata = {30'h0, st_r.mode == WDP_OST, enabled};
        default:         st_nxt.rdata = 32'h0;
      endcase
    end
    // Low frequency tick derived from the system clock.
    st_nxt.lf_tick = 1'b0;
    if (st_r.lf_cnt >= 16'(LF_DIV - 1)) begin
      st_nxt.lf_cnt  = 16'h0;
      st_nxt.lf_tick = 1'b1;
    end else begin
      st_nxt.lf_cnt = st_r.lf_cnt + 16'h1;
    end
    // Start-up counter reuses the watchdog ripple chain.
    unique case (st_r.mode)
      WDP_RUN: begin
        if (wake_event && wake_crystal) begin
          st_nxt.mode = WDP_OST;
          st_nxt.ost_cnt = 11'h0;
        end
      end
      WDP_OST: begin
        if (st_r.lf_tick) begin
          st_nxt.ost_cnt = st_r.ost_cnt + 11'h1;
          if (st_r.ost_cnt == 11'(OST_LEN - 1)) begin
            st_nxt.mode = WDP_RUN;
          end
        end
      end
    endcase
    // Prescaler chain; a clear or an overflow restarts both stages.
    if (clr_cnt || wdt_ovf) begin
      st_nxt.pre16 = 16'h0;
      st_nxt.pre8  = 8'h0;
    end else if (st_r.lf_tick) begin
      st_nxt.pre16 = pre16_hit ? 16'h0 : st_r.pre16 + 16'h1;
      if (pre16_hit && st_r.option[WDP_PSA_BIT]) begin
        st_nxt.pre8 = st_r.pre8 + 8'h1;
      end
    end
    // Overflow becomes a reset pulse when awake and a wake pulse in sleep.
    st_nxt.rst_pulse  = wdt_ovf & ~core_sleeping;
    st_nxt.wake_pulse = wdt_ovf & core_sleeping;
    // A watchdog reset reloads both control registers to their reset values.
    if (st_r.rst_pulse) begin
      st_nxt.wdctl  = WDP_WDCTL_RST;
      st_nxt.option = WDP_OPTION_RST;
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r        <= '0;
      st_r.wdctl  <= WDP_WDCTL_RST;
      st_r.option <= WDP_OPTION_RST;
      st_r.mode   <= WDP_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs.
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;
  assign low_freq_osc_status  = low_freq_osc_on;
  assign watchdog_reset       = st_r.rst_pulse;
  assign watchdog_wake        = st_r.wake_pulse;
  assign timer_prescaler_free = ~st_r.option[WDP_PSA_BIT];

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  // The acknowledge lasts a single cycle.
  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  // An acknowledge only answers a request that stood in the cycle before.
  a_ack_needs_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");

  // A control write lands at the next edge, with the upper bits masked.
  a_write_takes: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en && wb_sel_i[0] && wb_adr_i == WDP_ADDR_WDCTL && !st_r.rst_pulse |=>
    st_r.wdctl == (($past(wb_dat_i[7:0])) & WDP_WDCTL_MASK)) else $error("write lost");

  // A timer option write lands whole at the next edge.
  a_option_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en && wb_sel_i[0] && wb_adr_i == WDP_ADDR_OPTION && !st_r.rst_pulse |=>
    st_r.option == $past(wb_dat_i[7:0])) else $error("option write lost");

  // A write with the low byte lane off leaves both registers alone.
  a_sel_blocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_en && !wb_sel_i[0] && !st_r.rst_pulse |=>
    $stable(st_r.wdctl) && $stable(st_r.option)) else $error("masked write landed");

  // Reading the timer option returns the register as it stood.
  a_option_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_en && wb_adr_i == WDP_ADDR_OPTION |=>
    wb_dat_o == {24'h0, $past(st_r.option)}) else $error("option read wrong");

  // Reading an unmapped offset returns zero.
  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_en && wb_adr_i != WDP_ADDR_WDCTL && wb_adr_i != WDP_ADDR_OPTION
    && wb_adr_i != WDP_ADDR_STATUS |=> wb_dat_o == 32'h0) else $error("unmapped read");

  // The unused control bits never hold a one.
  a_ctl_high_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.wdctl[7:5] == 3'h0) else $error("control high bits set");

  // ----------------------------------------------------------------------------
  // Enable and clear sources
  // ----------------------------------------------------------------------------
  // The synchronised configuration enable forces the watchdog on.
  a_cfg_forces_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.cfg_sync[1] |-> enabled) else $error("config enable ignored");

  // A disabled watchdog never resets the core.
  a_off_no_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !enabled |=> !watchdog_reset) else $error("reset while off");

  // A disabled watchdog keeps both prescalers cleared.
  a_disabled_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !enabled |=> st_r.pre16 == 16'h0 && st_r.pre8 == 8'h0) else $error("count while off");

  // The clear instruction restarts the count.
  a_clear_instr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clear_watchdog_instr |=> st_r.pre16 == 16'h0) else $error("clear missed");

  // An oscillator failure restarts the count.
  a_osc_fail_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    osc_fail |=> st_r.pre16 == 16'h0 && st_r.pre8 == 8'h0) else $error("fail clear missed");

  // A wake without a crystal clock restarts the count.
  a_fast_wake_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wake_event && !wake_crystal |=> st_r.pre16 == 16'h0) else $error("wake clear missed");

  // ----------------------------------------------------------------------------
  // Start-up counter
  // ----------------------------------------------------------------------------
  // A wake with a crystal clock starts the start-up count.
  a_crystal_ost: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wake_event && wake_crystal && st_r.mode == WDP_RUN |=> st_r.mode == WDP_OST)
    else $error("start-up not entered");

  // No overflow comes out while the start-up counter owns the chain.
  a_ost_no_ovf: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.mode == WDP_OST |=> !watchdog_reset && !watchdog_wake) else $error("ovf in startup");

  // The watchdog count stays cleared during the start-up count.
  a_ost_holds_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.mode == WDP_OST |=> st_r.pre16 == 16'h0) else $error("count during startup");

  // The start-up count never ends before its last tick.
  a_ost_stays: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.mode == WDP_OST && !(st_r.lf_tick && st_r.ost_cnt == 11'(OST_LEN - 1)) |=>
    st_r.mode == WDP_OST) else $error("startup ended early");

  // The start-up counter stays below its length while running.
  a_ost_count_max: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.mode == WDP_OST |-> st_r.ost_cnt < 11'(OST_LEN)) else $error("startup overrun");

  // The last start-up tick hands the chain back to the watchdog.
  a_ost_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.mode == WDP_OST && st_r.lf_tick && st_r.ost_cnt == 11'(OST_LEN - 1) |=>
    st_r.mode == WDP_RUN) else $error("startup not released");

  // ----------------------------------------------------------------------------
  // Time base and overflow
  // ----------------------------------------------------------------------------
  // Oscillator ticks are single cycles; this needs a divider of two or more.
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.lf_tick |=> !st_r.lf_tick) else $error("tick too long");

  // The tick divider stays inside its range.
  a_lf_cnt_range: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.lf_cnt < 16'(LF_DIV)) else $error("divider out of range");

  // Reserved period codes fall back to the longest ratio.
  a_ps_code_clamp: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ps_code <= WDP_PS_MAXCODE) else $error("period code out of range");

  // With the shared prescaler given to the timer, the watchdog never advances it.
  a_pre8_parked: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !st_r.option[WDP_PSA_BIT] |=> st_r.pre8 == $past(st_r.pre8) || st_r.pre8 == 8'h0)
    else $error("shared prescaler moved");

  // An overflow pulse always follows an oscillator tick.
  a_ovf_on_tick: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watchdog_reset || watchdog_wake |-> $past(st_r.lf_tick)) else $error("ovf off tick");

  // The reset pulse lasts a single cycle.
  a_reset_one_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watchdog_reset |=> !watchdog_reset) else $error("reset pulse too long");

  // A wake pulse only comes out of sleep, never with a reset.
  a_sleep_wake: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watchdog_wake |-> $past(core_sleeping) && !watchdog_reset) else $error("bad wake");

  // A reset pulse only comes while the core is awake.
  a_reset_awake: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watchdog_reset |-> !$past(core_sleeping)) else $error("reset while sleeping");

  // A watchdog reset reloads the control register.
  a_reset_reload: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watchdog_reset |=> st_r.wdctl == WDP_WDCTL_RST) else $error("no reload");

  // The oscillator status follows only its own enable.
  a_status_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
    low_freq_osc_status == low_freq_osc_on) else $error("status follows watchdog");

  // Main scenarios: overflow awake and asleep, start-up end, forced on, clear.
  c_reset_seen: cover property (@(posedge clk_sys) disable iff (!arst_n) watchdog_reset);
  c_wake_seen: cover property (@(posedge clk_sys) disable iff (!arst_n) watchdog_wake);
  c_ost_end: cover property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.mode == WDP_OST ##1 st_r.mode == WDP_RUN);
  c_cfg_forced: cover property (@(posedge clk_sys) disable iff (!arst_n)
    st_r.cfg_sync[1] && watchdog_reset);
  c_clear_seen: cover property (@(posedge clk_sys) disable iff (!arst_n)
    clear_watchdog_instr && enabled);
endmodule

//--- dv/wdp_top_tb.sv
// Self-checking testbench for the watchdog block.
`timescale 1ns/1ps
module wdp_top_tb;
  import wdp_pkg::*;
  localparam int LFD = 2;
  logic        clk_sys, arst_n, cyc, we, cfg, clr, ofl, wk, xt, slp, lfo;
  logic [3:0]  adr, sel;
  logic [31:0] dw, dr, rd;
  logic        ack, wrst, wwak, lfs, tpf;
  int          error_cnt, comparisons, ncyc, n;

  wdp_top #(.LF_DIV(LFD), .OST_LEN(4)) i_wdp_top (.clk_sys(clk_sys), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dw),
    .wb_sel_i(sel), .wb_dat_o(dr), .wb_ack_o(ack), .watchdog_config_enable(cfg),
    .clear_watchdog_instr(clr), .osc_fail(ofl), .wake_event(wk), .wake_crystal(xt),
    .core_sleeping(slp), .low_freq_osc_on(lfo), .low_freq_osc_status(lfs),
    .watchdog_reset(wrst), .watchdog_wake(wwak), .timer_prescaler_free(tpf));

  // ---------------------------------------------------------------------------
  // Clock, cycle ceiling and shared tasks
  // ---------------------------------------------------------------------------
  // A hang past the ceiling counts as a mismatch.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    ncyc++;
    if (ncyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; holds the request until ack is sampled high.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
  endtask

  // Counts cycles until an overflow pulse shows, at most lim.
  task automatic wait_out(input int lim, output int cnt);
    cnt = 0;
    while (wrst !== 1'b1 && wwak !== 1'b1 && cnt < lim) begin
      @(posedge clk_sys);
      cnt++;
    end
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys);
    clr <= (k == 0);
    ofl <= (k == 1);
    wk <= (k == 2);
    @(posedge clk_sys);
    {clr, ofl, wk} <= 3'b000;
  endtask

  // Enables the watchdog and measures the time to overflow.
  task automatic period(input logic [3:0] code, input logic [7:0] opt, input logic s,
                        input logic c);
    int exp;
    exp = (32 << code) * (opt[3] ? 2 : 1) * LFD;
    slp <= s;
    xfer(1, WDP_ADDR_OPTION, {24'h0, opt}, 4'hf);
    chk(tpf, !opt[3], "prescaler owner");
    cfg <= c;
    xfer(1, WDP_ADDR_WDCTL, {27'h0, code, !c}, 4'hf);
    xfer(0, WDP_ADDR_STATUS, 0, 4'hf);
    chk(rd[0], 1, "effective enable");
    wait_out(exp + 40, n);
    chk(32'(n >= exp - 8 && n <= exp + 8), 1, "overflow time");
    chk({wwak, wrst}, {s, !s}, "overflow kind");
    cfg <= 1'b0;
    if (!s) xfer(0, WDP_ADDR_WDCTL, 0, 4'hf);
    if (!s) chk(rd, 32'h08, "reload after reset");
    xfer(1, WDP_ADDR_WDCTL, 0, 4'hf);
    slp <= 1'b0;
    $display("period code %0d opt %h done", code, opt);
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    {arst_n, cyc, we, cfg, clr, ofl, wk, xt, slp, lfo} = '0;
    adr = 4'h0;
    sel = 4'h0;
    dw = 32'h0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    xfer(0, WDP_ADDR_WDCTL, 0, 4'hf);
    chk(rd, 32'h08, "control reset");
    xfer(0, WDP_ADDR_OPTION, 0, 4'hf);
    chk(rd, 32'hff, "option reset");
    lfo <= 1'b1;
    xfer(0, WDP_ADDR_STATUS, 0, 4'hf);
    chk({lfs, tpf, rd[0]}, 3'b100, "status after reset");
    xfer(1, WDP_ADDR_WDCTL, 32'h1, 4'h0);
    xfer(0, WDP_ADDR_WDCTL, 0, 4'hf);
    chk(rd, 32'h08, "byte lane off");
    xfer(1, WDP_ADDR_WDCTL, 32'hff, 4'hf);
    xfer(0, WDP_ADDR_WDCTL, 0, 4'hf);
    chk(rd, 32'h1f, "upper bits");
    xfer(0, 4'hc, 0, 4'hf);
    chk(rd, 32'h0, "unmapped read");
    xfer(1, WDP_ADDR_WDCTL, 0, 4'hf);
    $display("registers done");
    period(4'h0, 8'h00, 0, 0);
    period(4'h1, 8'h00, 0, 0);
    period(4'h0, 8'h08, 0, 0);
    period(4'h0, 8'h00, 1, 0);
    period(4'h0, 8'h00, 0, 1);
    for (int k = 0; k < 3; k++) begin
      xfer(1, WDP_ADDR_OPTION, 32'h0, 4'hf);
      xfer(1, WDP_ADDR_WDCTL, 32'h1, 4'hf);
      repeat (4) begin
        wait_out(40, n);
        chk(n, 40, "cleared count");
        pulse(k);
      end
      xfer(1, WDP_ADDR_WDCTL, 32'h0, 4'hf);
      wait_out(100, n);
      chk(n, 100, "disabled");
      $display("clear source %0d done", k);
    end
    xfer(1, WDP_ADDR_WDCTL, 32'h1, 4'hf);
    xt <= 1'b1;
    pulse(2);
    xfer(0, WDP_ADDR_STATUS, 0, 4'hf);
    chk(rd[1:0], 2'b11, "start-up running");
    wait_out(200, n);
    chk(32'(n >= 32 * LFD + 2 && n <= 32 * LFD + 20), 1, "start after count");
    xt <= 1'b0;
    $display("crystal wake done");
    tally_and_finish();
  end
endmodule
